// [rtl/pbcs_pkg.sv]
`default_nettype none
package pbcs_pkg;
  // register byte addresses on the avalon slave
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BW = 8'h04;
  localparam logic [7:0] ADDR_MUL = 8'h08;
  localparam logic [7:0] ADDR_RANGE = 8'h0C;
  localparam logic [7:0] ADDR_REFDIV = 8'h10;
  // pll_control_reg field positions
  localparam int BIT_IE = 7;
  localparam int BIT_FLAG = 6;
  localparam int BIT_PON = 5;
  localparam int BIT_BCS = 4;
  localparam int BIT_PRE_HI = 3;
  localparam int BIT_PRE_LO = 2;
  localparam int BIT_VPR_HI = 1;
  localparam int BIT_VPR_LO = 0;
  // bandwidth_ctrl_reg field positions
  localparam int BIT_AUTO = 7;
  localparam int BIT_LOCK = 6;
  // widths and reset values
  localparam int MUL_W = 12;
  localparam int RANGE_W = 8;
  localparam int REFDIV_W = 4;
  localparam logic [MUL_W-1:0] MUL_RESET = 12'h040;
  localparam logic [RANGE_W-1:0] RANGE_RESET = 8'h40;
  localparam logic [REFDIV_W-1:0] REFDIV_RESET = 4'h1;
  localparam logic [1:0] PRE_RESET = 2'h0;
  localparam logic [1:0] VPR_RESET = 2'h0;
  // source clock edges to wait during a base clock handover
  localparam logic [1:0] SWITCH_EDGES = 2'h3;
  // divider terminal counts, in source clock edges (rise and fall)
  localparam logic [1:0] OSC_HALF_EDGES = 2'h2;
  localparam logic [1:0] VCO_HALF_EDGES = 2'h3;
  // base clock selector states
  typedef enum logic [1:0] {PBCS_RUN, PBCS_HOLD} pbcs_sel_e;
endpackage
`default_nettype wire

// [rtl/pbcs_sync_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface pbcs_sync_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// [rtl/pbcs_sync.sv]
`timescale 1ns/10ps
`default_nettype none
// three flop synchroniser; a change counts once stages two and three agree
module pbcs_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  pbcs_sync_if.src sync
);
  logic meta;
  logic stage2;
  logic stage3;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end
    else
    begin
      meta <= async_i;
      stage2 <= meta;
      stage3 <= stage2;
    end
  end

  // filtered level with one cycle change pulses
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sync.level <= 1'b0;
      sync.rise <= 1'b0;
      sync.fall <= 1'b0;
    end
    else
    begin
      sync.rise <= (stage2 == stage3) && stage3 && !sync.level;
      sync.fall <= (stage2 == stage3) && !stage3 && sync.level;
      if (stage2 == stage3)
      begin
        sync.level <= stage3;
      end
    end
  end
endmodule // pbcs_sync
`default_nettype wire

// [rtl/pbcs_top.sv]
`timescale 1ns/10ps
`default_nettype none
// What this block does
// RL1: reference divider or multiplier value zero behaves exactly like value one.
// RL2: range multiplier zero disables pll, refuses vco selection, forces oscillator source.
// RL3: select bit one gives vco divided by three, zero oscillator by two.
// RL4: base clock held static during source change, within three plus three cycles.
// RL5: base clock has fifty percent duty, twice bus frequency.
// RL6: setting base select is ignored while pll power bit is clear.
// RL7: clearing pll power is refused while base select is one.
// RL8: power-on and vco selection need two separate control writes.
// RL9: power bit set enables pll and vco clock; clear stops it.
// RL10: reset sets power bit and keeps oscillator as base source.
// RL11: lock toggle sets change flag; flag with enable raises interrupt.
// RL12: interrupt enable unwritable, reads zero with auto mode off; reset clears.
// RL13: change flag reads zero with auto mode off; reset clears it.
// RL14: any control register read clears the change flag; a lock toggle in the same cycle sets it instead.
// RL15: prescaler bits unwritable while pll powered; reset clears them.
// RL16: prescaler code selects multiplier one, two, four or eight.
// RL17: lock indicator read-only in auto mode, reads zero otherwise.
// RL18: range exponent bits unwritable while powered, reset clears; never program three.
// RL19: bits blocked by an interlock keep old values, others still update.
module pbcs_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic osc_clock_i,
  input wire logic vco_clock_i,
  input wire logic lock_i,
  output logic base_clock_out_o,
  output logic pll_irq_o,
  output logic pll_enable_o,
  output logic [1:0] prescale_o,
  output logic [1:0] vco_range_exp_o,
  output logic [pbcs_pkg::MUL_W-1:0] mul_eff_o,
  output logic [pbcs_pkg::REFDIV_W-1:0] ref_div_eff_o,
  output logic [pbcs_pkg::RANGE_W-1:0] vco_range_o
);
  pbcs_sync_if osc_s (), vco_s (), lock_s ();
  pbcs_sync u_osc (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(osc_clock_i), .sync(osc_s));
  pbcs_sync u_vco (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(vco_clock_i), .sync(vco_s));
  pbcs_sync u_lock (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(lock_i), .sync(lock_s));
  logic lock_irq_enable, lock_change_flag, pll_power_on, base_source_select, auto_mode;
  logic [1:0] prescale, vco_range_exp;
  logic [pbcs_pkg::MUL_W-1:0] mul;
  logic [pbcs_pkg::RANGE_W-1:0] range;
  logic [pbcs_pkg::REFDIV_W-1:0] ref_div;
  logic acc, wr_go, rd_go, wr_lane0, range_zero;
  logic [7:0] wd, ctrl_rd;
  logic [31:0] next_readdata;
  // a request is served on the edge where waitrequest is low
  assign acc = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
  assign wr_go = acc && avs_write_i;
  assign rd_go = acc && avs_read_i;
  assign wr_lane0 = wr_go && avs_byteenable_i[0];
  assign wd = avs_writedata_i[7:0];
  assign range_zero = (range == '0);
  // one wait state: waitrequest drops for exactly one cycle per request
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
  end
  // control read view; masked bits read zero outside auto mode
  always_comb
  begin
    ctrl_rd = '0;
    ctrl_rd[pbcs_pkg::BIT_IE] = lock_irq_enable && auto_mode; // RL12
    ctrl_rd[pbcs_pkg::BIT_FLAG] = lock_change_flag && auto_mode; // RL13
    ctrl_rd[pbcs_pkg::BIT_PON] = pll_power_on;
    ctrl_rd[pbcs_pkg::BIT_BCS] = base_source_select;
    ctrl_rd[pbcs_pkg::BIT_PRE_HI] = prescale[1];
    ctrl_rd[pbcs_pkg::BIT_PRE_LO] = prescale[0];
    ctrl_rd[pbcs_pkg::BIT_VPR_HI] = vco_range_exp[1];
    ctrl_rd[pbcs_pkg::BIT_VPR_LO] = vco_range_exp[0];
  end
  // read mux; unmapped addresses read zero
  always_comb
  begin
    next_readdata = '0;
    case (avs_address_i)
      pbcs_pkg::ADDR_CTRL: next_readdata[7:0] = ctrl_rd;
      pbcs_pkg::ADDR_BW:
      begin
        next_readdata[pbcs_pkg::BIT_AUTO] = auto_mode;
        next_readdata[pbcs_pkg::BIT_LOCK] = lock_s.level && auto_mode; // RL17
      end
      pbcs_pkg::ADDR_MUL: next_readdata[pbcs_pkg::MUL_W-1:0] = mul;
      pbcs_pkg::ADDR_RANGE: next_readdata[pbcs_pkg::RANGE_W-1:0] = range;
      pbcs_pkg::ADDR_REFDIV: next_readdata[pbcs_pkg::REFDIV_W-1:0] = ref_div;
      default: next_readdata = '0;
    endcase
  end
  // read data captured during the wait cycle, stands at the serving edge
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      avs_readdata_o <= '0;
    else if (avs_read_i && avs_waitrequest_o)
      avs_readdata_o <= next_readdata;
  end
  // power and source select interlocks, judged on the old register values
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pll_power_on <= 1'b1; // RL10
      base_source_select <= 1'b0; // RL3 RL10
    end
    else
    begin
      if (wr_lane0 && avs_address_i == pbcs_pkg::ADDR_CTRL)
      begin
        // clear refused while vco drives the base clock
        if (!base_source_select) // RL7 RL19
          pll_power_on <= wd[pbcs_pkg::BIT_PON]; // RL9
        // set refused while pll off or range zero; same write cannot do both
        if (!wd[pbcs_pkg::BIT_BCS] || (pll_power_on && !range_zero)) // RL6 RL8 RL2 RL19
          base_source_select <= wd[pbcs_pkg::BIT_BCS];
      end
      if (range_zero) // RL2
        base_source_select <= 1'b0;
    end
  end
  // prescaler and range exponent frozen while the pll is powered
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      prescale <= pbcs_pkg::PRE_RESET; // RL15
      vco_range_exp <= pbcs_pkg::VPR_RESET; // RL18
      lock_irq_enable <= 1'b0; // RL12
    end
    else if (wr_lane0 && avs_address_i == pbcs_pkg::ADDR_CTRL)
    begin
      if (!pll_power_on) // RL15 RL18 RL19
      begin
        prescale <= {wd[pbcs_pkg::BIT_PRE_HI], wd[pbcs_pkg::BIT_PRE_LO]};
        vco_range_exp <= {wd[pbcs_pkg::BIT_VPR_HI], wd[pbcs_pkg::BIT_VPR_LO]};
      end
      if (auto_mode) // RL12
        lock_irq_enable <= wd[pbcs_pkg::BIT_IE];
    end
  end
  // divider registers, also frozen while powered
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      auto_mode <= 1'b0;
      mul <= pbcs_pkg::MUL_RESET;
      range <= pbcs_pkg::RANGE_RESET;
      ref_div <= pbcs_pkg::REFDIV_RESET;
    end
    else if (wr_go)
    begin
      if (avs_byteenable_i[0] && avs_address_i == pbcs_pkg::ADDR_BW)
        auto_mode <= wd[pbcs_pkg::BIT_AUTO];
      if (!pll_power_on && avs_address_i == pbcs_pkg::ADDR_MUL)
      begin
        if (avs_byteenable_i[0])
          mul[7:0] <= wd;
        if (avs_byteenable_i[1])
          mul[pbcs_pkg::MUL_W-1:8] <= avs_writedata_i[pbcs_pkg::MUL_W-1:8];
      end
      if (!pll_power_on && avs_byteenable_i[0] && avs_address_i == pbcs_pkg::ADDR_RANGE)
        range <= wd;
      if (!pll_power_on && avs_byteenable_i[0] && avs_address_i == pbcs_pkg::ADDR_REFDIV)
        ref_div <= wd[pbcs_pkg::REFDIV_W-1:0];
    end
  end
  // lock change flag: a toggle in the clearing cycle still sets it
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      lock_change_flag <= 1'b0; // RL13
    else if (!auto_mode)
      lock_change_flag <= 1'b0; // RL13
    else if (lock_s.rise || lock_s.fall) // RL11
      lock_change_flag <= 1'b1;
    else if (rd_go && avs_address_i == pbcs_pkg::ADDR_CTRL) // RL14
      lock_change_flag <= 1'b0;
  end
  // registered outputs toward the analog loop and the integration unit
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pll_irq_o <= 1'b0;
      pll_enable_o <= 1'b0;
      prescale_o <= pbcs_pkg::PRE_RESET;
      vco_range_exp_o <= pbcs_pkg::VPR_RESET;
      mul_eff_o <= pbcs_pkg::MUL_RESET;
      ref_div_eff_o <= pbcs_pkg::REFDIV_RESET;
      vco_range_o <= pbcs_pkg::RANGE_RESET;
    end
    else
    begin
      pll_irq_o <= lock_change_flag && lock_irq_enable && auto_mode; // RL11
      pll_enable_o <= pll_power_on && !range_zero; // RL9 RL2
      prescale_o <= prescale; // RL16
      vco_range_exp_o <= vco_range_exp;
      // zero divider settings behave as one
      mul_eff_o <= (mul == '0) ? pbcs_pkg::MUL_W'(1) : mul; // RL1
      ref_div_eff_o <= (ref_div == '0) ? pbcs_pkg::REFDIV_W'(1) : ref_div; // RL1
      vco_range_o <= range;
    end
  end

  // source dividers count both edges so each half period is equal
  logic [1:0] osc_cnt, vco_cnt;
  logic osc_div, vco_div, osc_edge, vco_edge;
  assign osc_edge = osc_s.rise || osc_s.fall;
  assign vco_edge = vco_s.rise || vco_s.fall;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      osc_cnt <= '0;
      osc_div <= 1'b0;
    end
    else if (osc_edge)
    begin
      if (osc_cnt == pbcs_pkg::OSC_HALF_EDGES - 2'h1) // RL5
      begin
        osc_cnt <= '0;
        osc_div <= !osc_div;
      end
      else
        osc_cnt <= osc_cnt + 2'h1;
    end
  end
  // vco stops counting while the pll is off
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      vco_cnt <= '0;
      vco_div <= 1'b0;
    end
    else if (vco_edge && pll_enable_o)
    begin
      if (vco_cnt == pbcs_pkg::VCO_HALF_EDGES - 2'h1) // RL5
      begin
        vco_cnt <= '0;
        vco_div <= !vco_div;
      end
      else
        vco_cnt <= vco_cnt + 2'h1;
    end
  end

  // handover: freeze the output, let the oscillator and, when it is selected, the vco run three rising edges
  pbcs_pkg::pbcs_sel_e sel_state;
  logic active_src;
  logic [1:0] osc_wait, vco_wait;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sel_state <= pbcs_pkg::PBCS_RUN;
      active_src <= 1'b0;
      osc_wait <= '0;
      vco_wait <= '0;
    end
    else
    begin
      case (sel_state)
        pbcs_pkg::PBCS_RUN:
          if (active_src != base_source_select) // RL4
          begin
            sel_state <= pbcs_pkg::PBCS_HOLD;
            osc_wait <= '0;
            vco_wait <= '0;
          end
        pbcs_pkg::PBCS_HOLD:
        begin
          if (osc_s.rise && osc_wait != pbcs_pkg::SWITCH_EDGES)
            osc_wait <= osc_wait + 2'h1;
          if (vco_s.rise && vco_wait != pbcs_pkg::SWITCH_EDGES)
            vco_wait <= vco_wait + 2'h1;
          // a dead vco must not trap the switch back to the oscillator
          if (osc_wait == pbcs_pkg::SWITCH_EDGES &&
              (vco_wait == pbcs_pkg::SWITCH_EDGES || !base_source_select)) // RL4
          begin
            active_src <= base_source_select;
            sel_state <= pbcs_pkg::PBCS_RUN;
          end
        end
        default: sel_state <= pbcs_pkg::PBCS_RUN;
      endcase
    end
  end
  // base clock output stays static while holding
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      base_clock_out_o <= 1'b0;
    else if (sel_state == pbcs_pkg::PBCS_RUN && active_src == base_source_select)
      base_clock_out_o <= active_src ? vco_div : osc_div; // RL3
  end

  // checks
  a_bcs_needs_power: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL6
    $rose(base_source_select) |-> $past(pll_power_on)) else $error("select set while pll off");
  a_power_held: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL7
    $past(base_source_select) |-> pll_power_on) else $error("pll cleared while vco selected");
  a_no_joint_change: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL8
    $rose(pll_power_on) |-> !$rose(base_source_select)) else $error("power and select in one write");
  a_range_zero_src: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL2
    range_zero |=> !base_source_select && !pll_enable_o) else $error("range zero kept vco");
  a_hold_static: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL4
    sel_state == pbcs_pkg::PBCS_HOLD |=> $stable(base_clock_out_o)) else $error("base clock moved in hold");
  a_pre_frozen: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL15
    $past(pll_power_on) |-> $stable(prescale) && $stable(vco_range_exp)) else $error("prescaler changed while on");
  a_flag_cleared: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL14
    rd_go && avs_address_i == pbcs_pkg::ADDR_CTRL && !lock_s.rise && !lock_s.fall |=> !lock_change_flag)
    else $error("control read left flag set");
  a_flag_on_toggle: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL11
    auto_mode && (lock_s.rise || lock_s.fall) |=> lock_change_flag) else $error("lock toggle lost");
  a_irq_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL11
    lock_change_flag && lock_irq_enable && auto_mode |=> pll_irq_o) else $error("irq missing");
  a_ie_masked: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL12 RL13
    avs_read_i && avs_waitrequest_o && avs_address_i == pbcs_pkg::ADDR_CTRL && !auto_mode
    |=> !avs_readdata_o[pbcs_pkg::BIT_IE] && !avs_readdata_o[pbcs_pkg::BIT_FLAG]) else $error("masked bits read");
  a_div_one: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL1
    mul == '0 |=> mul_eff_o == pbcs_pkg::MUL_W'(1)) else $error("zero multiplier not one");
endmodule // pbcs_top
`default_nettype wire

// [sim/pbcs_siu_model.sv]
`timescale 1ns/10ps
`default_nettype none
// clock sources in front of the block and a meter on the base clock it hands back
module pbcs_siu_model #(
  parameter int OSC_HALF_NS = 40,
  parameter int VCO_HALF_NS = 30
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pll_enable_i,
  input wire logic base_clock_i,
  output logic osc_clock_o,
  output logic vco_clock_o,
  output logic [7:0] hi_len_o,
  output logic [7:0] lo_len_o,
  output logic [15:0] toggles_o
);
  logic prev_q;
  logic [7:0] run_q;

  // oscillator runs free; odd offset keeps its edges away from clk_i edges
  initial
  begin
    osc_clock_o = 1'b0;
    #1.3;
    forever #OSC_HALF_NS osc_clock_o = ~osc_clock_o;
  end

  // vco stands still low while the loop is disabled
  initial
  begin
    vco_clock_o = 1'b0;
    #2.1;
    forever
    begin
      #VCO_HALF_NS;
      vco_clock_o = pll_enable_i ? ~vco_clock_o : 1'b0;
    end
  end

  // length of each finished base clock phase, in system clock cycles
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      prev_q <= 1'b0;
      run_q <= 8'h00;
      hi_len_o <= 8'h00;
      lo_len_o <= 8'h00;
      toggles_o <= 16'h0000;
    end
    else if (base_clock_i != prev_q)
    begin
      prev_q <= base_clock_i;
      run_q <= 8'h00;
      toggles_o <= toggles_o + 16'h0001;
      if (prev_q)
        hi_len_o <= run_q + 8'h01;
      else
        lo_len_o <= run_q + 8'h01;
    end
    else
      run_q <= run_q + 8'h01;
  end
endmodule // pbcs_siu_model
`default_nettype wire

// [sim/pll_base_clock_selector_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module pll_base_clock_selector_bench;
  logic clk_i, rst_n_i, avs_read_i, avs_write_i, lock_i;
  logic [7:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd_q;
  logic [3:0] avs_byteenable_i;
  logic avs_waitrequest_o, osc_clock, vco_clock, base_clock_out_o, pll_irq_o, pll_enable_o;
  logic [1:0] prescale_o, vco_range_exp_o;
  logic [pbcs_pkg::MUL_W-1:0] mul_eff_o;
  logic [pbcs_pkg::REFDIV_W-1:0] ref_div_eff_o;
  logic [pbcs_pkg::RANGE_W-1:0] vco_range_o;
  logic [7:0] hi_len, lo_len;
  logic [15:0] toggles;
  int err_total, compares;

  pbcs_top i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .osc_clock_i(osc_clock),
    .vco_clock_i(vco_clock), .lock_i(lock_i), .base_clock_out_o(base_clock_out_o), .pll_irq_o(pll_irq_o),
    .pll_enable_o(pll_enable_o), .prescale_o(prescale_o), .vco_range_exp_o(vco_range_exp_o),
    .mul_eff_o(mul_eff_o), .ref_div_eff_o(ref_div_eff_o), .vco_range_o(vco_range_o));

  pbcs_siu_model i_siu (.clk_i(clk_i), .rst_n_i(rst_n_i), .pll_enable_i(pll_enable_o),
    .base_clock_i(base_clock_out_o), .osc_clock_o(osc_clock), .vco_clock_o(vco_clock),
    .hi_len_o(hi_len), .lo_len_o(lo_len), .toggles_o(toggles));

  // 200 MHz system clock
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic summarize;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one avalon transfer; waitrequest and readdata are taken at the rising edge that serves it
  task automatic bus(input logic rd, input logic [7:0] addr, input logic [31:0] data);
    int n;
    @(posedge clk_i);
    avs_read_i <= rd;
    avs_write_i <= ~rd;
    avs_address_i <= addr;
    avs_writedata_i <= data;
    @(posedge clk_i);
    n = 1;
    while (avs_waitrequest_o !== 1'b0 && n < 40)
    begin
      @(posedge clk_i);
      n++;
    end
    rd_q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (avs_waitrequest_o !== 1'b0)
    begin
      err_total++;
      $display("mismatch at %0t: bus transfer never served", $time);
      summarize();
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    bus(1'b0, addr, data);
  endtask

  task automatic chk(input logic [7:0] addr, input logic [31:0] exp);
    bus(1'b1, addr, 32'h0000_0000);
    cmp(rd_q, exp, "register read");
  endtask

  // waits for base clock activity; a stuck clock counts as a mismatch
  task automatic edges(input int cnt, input int bound);
    int n;
    logic [15:0] t0;
    t0 = toggles;
    n = 0;
    while (toggles - t0 < cnt[15:0] && n < bound)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= bound)
    begin
      err_total++;
      $display("mismatch at %0t: base clock stalled", $time);
      summarize();
    end
  endtask

  // both phases within one cycle of the expected half period
  task automatic duty(input logic [7:0] half);
    edges(4, 3000);
    cmp({31'h0, (hi_len >= half - 8'h01 && hi_len <= half + 8'h01)}, 32'h1, "high phase length");
    cmp({31'h0, (lo_len >= half - 8'h01 && lo_len <= half + 8'h01)}, 32'h1, "low phase length");
  endtask

  initial
  begin
    rst_n_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 8'h00;
    avs_writedata_i = 32'h0000_0000;
    avs_byteenable_i = 4'hF;
    lock_i = 1'b0;
    err_total = 0;
    compares = 0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // reset state of every register
    chk(pbcs_pkg::ADDR_CTRL, 32'h0000_0020);
    chk(pbcs_pkg::ADDR_BW, 32'h0000_0000);
    chk(pbcs_pkg::ADDR_MUL, 32'h0000_0040);
    chk(pbcs_pkg::ADDR_RANGE, 32'h0000_0040);
    chk(pbcs_pkg::ADDR_REFDIV, 32'h0000_0001);
    chk(8'h14, 32'h0000_0000);
    cmp({31'h0, pll_enable_o}, 32'h1, "enable after reset");
    duty(8'h10);
    // power down, then select with power off is ignored
    wr(pbcs_pkg::ADDR_CTRL, 32'h0000_0000);
    chk(pbcs_pkg::ADDR_CTRL, 32'h0000_0000);
    repeat (3) @(posedge clk_i);
    cmp({31'h0, pll_enable_o}, 32'h0, "enable after power off");
    wr(pbcs_pkg::ADDR_CTRL, 32'h0000_0010);
    chk(pbcs_pkg::ADDR_CTRL, 32'h0000_0000);
    // every prescaler code, with legal range exponents, while powered down
    for (int p = 0; p < 4; p++)
    begin
      wr(pbcs_pkg::ADDR_CTRL, p * 4 + p % 3);
      chk(pbcs_pkg::ADDR_CTRL, p * 4 + p % 3);
      cmp({30'h0, prescale_o}, p, "prescale code");
      cmp({30'h0, vco_range_exp_o}, p % 3, "range exponent");
    end
    // upper multiplier lane, then zero divider values act as one
    wr(pbcs_pkg::ADDR_MUL, 32'h0000_0123);
    chk(pbcs_pkg::ADDR_MUL, 32'h0000_0123);
    wr(pbcs_pkg::ADDR_MUL, 32'h0000_0000);
    wr(pbcs_pkg::ADDR_REFDIV, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    cmp({20'h0, mul_eff_o}, 32'h1, "effective multiplier");
    cmp({28'h0, ref_div_eff_o}, 32'h1, "effective divider");
    // power and select in one write: power only
    wr(pbcs_pkg::ADDR_CTRL, 32'h0000_0030);
    chk(pbcs_pkg::ADDR_CTRL, 32'h0000_0020);
    // powered: prescale and exponent held, select still taken
    wr(pbcs_pkg::ADDR_CTRL, 32'h0000_003F);
    chk(pbcs_pkg::ADDR_CTRL, 32'h0000_0030);
    wr(pbcs_pkg::ADDR_MUL, 32'h0000_0123);
    chk(pbcs_pkg::ADDR_MUL, 32'h0000_0000);
    edges(1, 130);
    duty(8'h12);
    // power clear refused while the vco drives the base clock
    wr(pbcs_pkg::ADDR_CTRL, 32'h0000_0010);
    chk(pbcs_pkg::ADDR_CTRL, 32'h0000_0030);
    wr(pbcs_pkg::ADDR_CTRL, 32'h0000_0000);
    chk(pbcs_pkg::ADDR_CTRL, 32'h0000_0020);
    edges(1, 80);
    duty(8'h10);
    // lock events are hidden while automatic mode is off
    lock_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk(pbcs_pkg::ADDR_CTRL, 32'h0000_0020);
    wr(pbcs_pkg::ADDR_CTRL, 32'h0000_00A0);
    chk(pbcs_pkg::ADDR_CTRL, 32'h0000_0020);
    chk(pbcs_pkg::ADDR_BW, 32'h0000_0000);
    // automatic mode: toggle sets flag, a read clears it
    wr(pbcs_pkg::ADDR_BW, 32'h0000_0080);
    chk(pbcs_pkg::ADDR_BW, 32'h0000_00C0);
    lock_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    cmp({31'h0, pll_irq_o}, 32'h0, "irq with enable off");
    chk(pbcs_pkg::ADDR_CTRL, 32'h0000_0060);
    chk(pbcs_pkg::ADDR_CTRL, 32'h0000_0020);
    wr(pbcs_pkg::ADDR_CTRL, 32'h0000_00A0);
    chk(pbcs_pkg::ADDR_CTRL, 32'h0000_00A0);
    lock_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    cmp({31'h0, pll_irq_o}, 32'h1, "irq raised");
    chk(pbcs_pkg::ADDR_CTRL, 32'h0000_00E0);
    repeat (3) @(posedge clk_i);
    cmp({31'h0, pll_irq_o}, 32'h0, "irq after read");
    // range multiplier zero disables the loop and refuses the vco
    wr(pbcs_pkg::ADDR_CTRL, 32'h0000_0080);
    wr(pbcs_pkg::ADDR_RANGE, 32'h0000_0000);
    chk(pbcs_pkg::ADDR_RANGE, 32'h0000_0000);
    cmp({24'h0, vco_range_o}, 32'h0, "range output");
    wr(pbcs_pkg::ADDR_CTRL, 32'h0000_00A0);
    wr(pbcs_pkg::ADDR_CTRL, 32'h0000_00B0);
    chk(pbcs_pkg::ADDR_CTRL, 32'h0000_00A0);
    repeat (3) @(posedge clk_i);
    cmp({31'h0, pll_enable_o}, 32'h0, "enable with zero range");
    duty(8'h10);
    summarize();
  end
endmodule // pll_base_clock_selector_bench
`default_nettype wire
